// ===== stop_pkg.sv
// Constants, field layouts and carrier types of the stop-mode controller.
// Assumes a single 125 MHz clock and an 8-bit register port.
package stop_pkg;

  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 8;

  // Register offsets.
  localparam logic [7:0] OFS_PWR_ONE = 8'h00;
  localparam logic [7:0] OFS_PWR_TWO = 8'h01;
  localparam logic [7:0] OFS_OPTION  = 8'h02;
  localparam logic [7:0] OFS_DEBUG   = 8'h03;
  localparam logic [7:0] OFS_CLKSTBY = 8'h04;
  localparam logic [7:0] OFS_KBD_EN  = 8'h05;
  localparam logic [7:0] OFS_STATUS  = 8'h06;

  // Field positions.
  localparam int unsigned B_LV_DET   = 0;
  localparam int unsigned B_LV_STOP  = 1;
  localparam int unsigned B_LV_RST   = 2;
  localparam int unsigned B_LV_FLAG  = 3;
  localparam int unsigned B_PPD_SEL  = 0;
  localparam int unsigned B_PD_SEL   = 1;
  localparam int unsigned B_PPD_FLAG = 2;
  localparam int unsigned B_PPD_ACK  = 3;
  localparam int unsigned B_PERMIT   = 0;
  localparam int unsigned B_DBG_EN   = 0;
  localparam int unsigned B_BG_ACT   = 1;
  localparam int unsigned B_OSC_KEEP = 0;
  localparam int unsigned B_REF_KEEP = 1;
  localparam int unsigned B_TMR_ON   = 2;
  localparam int unsigned B_TMR_EXT  = 3;
  localparam int unsigned B_IN_STOP  = 2;

  // Reset values.
  localparam logic [7:0] PWR_ONE_RST = 8'h00;
  localparam logic [7:0] PWR_TWO_RST = 8'h00;
  localparam logic [7:0] OPTION_RST  = 8'h00;
  localparam logic [7:0] DEBUG_RST   = 8'h00;
  localparam logic [7:0] CLKSTBY_RST = 8'h00;
  localparam logic [7:0] KBD_EN_RST  = 8'h00;

  typedef enum logic [1:0] {LVL_NONE, LVL_DEEP, LVL_MID, LVL_LIGHT} level_t;

  typedef struct packed {
    logic dbg_en;
    logic lv_det_en;
    logic lv_stop_en;
    logic pd_sel;
    logic ppd_sel;
    logic osc_keep;
    logic ref_keep;
    logic timer_on;
    logic timer_ext;
  } stop_req_t;

  typedef struct packed {
    level_t level;
    logic   reg_full;
    logic   dbg_clk;
    logic   lvd_on;
    logic   osc_keep;
    logic   ref_keep;
    logic   int1k_en;
    logic   pin_hold;
    logic   pin_force;
    logic   ram_keep;
    logic   kbd_wake;
    logic   timer_wake;
  } stop_plan_t;

  typedef struct packed {
    logic periph_clk_en;
    logic dbg_clk_en;
    logic reg_full;
    logic clkgen_standby;
    logic clkgen_off;
    logic osc_keep;
    logic ref_keep;
    logic int1k_en;
    logic pin_hold;
    logic pin_force_reset;
    logic ram_keep;
    logic conv_standby;
    logic kbd_wake_en;
    logic timer_wake_en;
  } power_ctl_t;

  typedef struct packed {
    logic valid;
    logic background;
    logic mem_status;
    logic go;
  } dbg_cmd_t;

  typedef struct packed {
    logic valid;
    logic stop_err;
    logic bg_active;
  } dbg_stat_t;

endpackage

// ===== pin_sync.sv
// Two-flop synchroniser for pins from outside the clock domain.
// Assumes the pins change slowly against the 125 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] d_in,
  output var  logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      meta_q <= RST_VAL;
      q_out  <= RST_VAL;
    end else begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ===== stop_level_resolver.sv
// Resolves the requested stop level into the effective level and its domains.
// Assumes the request is sampled by its user when STOP executes.
`timescale 1ns/1ps
`default_nettype none
module stop_level_resolver (
  input  wire stop_pkg::stop_req_t  req_in,
  output var  stop_pkg::stop_plan_t plan_out
);

  stop_pkg::level_t asked;

  always_comb begin
    asked = req_in.pd_sel ? (req_in.ppd_sel ? stop_pkg::LVL_MID : stop_pkg::LVL_DEEP)
                          : stop_pkg::LVL_LIGHT;
    plan_out = '0;
    plan_out.level = (req_in.dbg_en || req_in.lv_stop_en) ? stop_pkg::LVL_LIGHT
                                                          : asked;
    plan_out.dbg_clk  = req_in.dbg_en;
    plan_out.lvd_on   = req_in.lv_det_en && req_in.lv_stop_en;
    plan_out.reg_full = req_in.dbg_en || plan_out.lvd_on;
    plan_out.ram_keep = (plan_out.level != stop_pkg::LVL_DEEP);
    plan_out.pin_hold  = (plan_out.level == stop_pkg::LVL_MID);
    plan_out.pin_force = (plan_out.level == stop_pkg::LVL_DEEP);
    plan_out.kbd_wake  = (plan_out.level == stop_pkg::LVL_LIGHT);
    plan_out.timer_wake = req_in.timer_on && (plan_out.level != stop_pkg::LVL_DEEP);
    if (plan_out.level == stop_pkg::LVL_LIGHT) begin
      plan_out.osc_keep = req_in.osc_keep;
      plan_out.ref_keep = req_in.ref_keep;
      plan_out.int1k_en = req_in.timer_on && !req_in.timer_ext && !req_in.dbg_en;
    end else begin
      plan_out.int1k_en = plan_out.timer_wake;
    end
  end

endmodule
`default_nettype wire

// ===== stop_mode_controller.sv
// Stop-mode controller: register port, level choice, stop domains and wake-up.
// Assumes STOP and debug commands come from logic on mclk_in; pins are async.
`timescale 1ns/1ps
`default_nettype none
module stop_mode_controller #(
  parameter int unsigned KBD_W = 8
) (
  input  wire logic                        mclk_in,
  input  wire logic                        rst_in,
  input  wire logic [stop_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [stop_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                        wr_in,
  input  wire logic                        rd_in,
  output var  logic [stop_pkg::DATA_W-1:0] rdata_out,
  input  wire logic                        stop_exec_in,
  input  wire logic                        rst_pin_n_in,
  input  wire logic                        irq_pin_n_in,
  input  wire logic [KBD_W-1:0]            kbd_pins_in,
  input  wire logic                        wake_tick_in,
  input  wire logic                        lowvolt_trip_in,
  input  wire stop_pkg::dbg_cmd_t          dbg_cmd_in,
  output var  stop_pkg::dbg_stat_t         dbg_stat_out,
  output var  stop_pkg::power_ctl_t        power_ctl_out,
  output var  stop_pkg::level_t            stop_level_out,
  output var  logic                        illegal_reset_out,
  output var  logic                        sys_reset_out,
  output var  logic                        resume_out,
  output var  logic                        lvd_irq_out,
  output var  logic                        lvd_reset_out
);

  // ****************************************************************
  // Parameter check.
  // ****************************************************************
  if (KBD_W < 1 || KBD_W > stop_pkg::DATA_W) begin : g_bad_kbd
    $error("KBD_W must lie between 1 and the data width.");
  end

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  localparam int unsigned SYNC_W = KBD_W + 3;
  localparam logic [SYNC_W-1:0] SYNC_RST = {{(KBD_W + 2){1'b1}}, 1'b0};

  logic [SYNC_W-1:0] sync_q;
  logic              rst_pin_n_s;
  logic              irq_n_s;
  logic [KBD_W-1:0]  kbd_s;
  logic              lv_s;

  pin_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .mclk_in (mclk_in),
    .rst_in  (rst_in),
    .d_in    ({rst_pin_n_in, irq_pin_n_in, kbd_pins_in, lowvolt_trip_in}),
    .q_out   (sync_q)
  );

  assign {rst_pin_n_s, irq_n_s, kbd_s, lv_s} = sync_q;

  // ****************************************************************
  // State.
  // ****************************************************************
  typedef enum logic {ST_RUN, ST_STOP} state_t;

  state_t               state_q, state_d;
  logic [7:0]           pwr_one_q, pwr_one_d;
  logic [7:0]           pwr_two_q, pwr_two_d;
  logic [7:0]           option_q, option_d;
  logic [7:0]           debug_q, debug_d;
  logic [7:0]           clkstby_q, clkstby_d;
  logic [KBD_W-1:0]     kbd_en_q, kbd_en_d;
  logic                 ppd_flag_q, ppd_flag_d;
  logic                 lvd_flag_q, lvd_flag_d;
  logic                 bg_active_q, bg_active_d;
  logic                 lv_prev_q;
  stop_pkg::stop_plan_t plan_q, plan_d;
  stop_pkg::power_ctl_t pctl_d;
  stop_pkg::dbg_stat_t  stat_d;
  logic [7:0]           rdata_d;
  logic                 illegal_d;
  logic                 sys_reset_d;
  logic                 resume_d;
  logic                 lvd_irq_d;
  logic                 lvd_reset_d;

  stop_pkg::stop_req_t  req;
  stop_pkg::stop_plan_t plan_now;
  logic                 stop_go;
  logic                 lvd_active;
  logic                 trip_evt;
  logic                 rst_wake;
  logic                 kbd_wake;
  logic                 tick_wake;
  logic                 bg_wake;
  logic                 wake;

  // ****************************************************************
  // Level resolution.
  // ****************************************************************
  always_comb begin
    req            = '0;
    req.dbg_en     = debug_q[stop_pkg::B_DBG_EN];
    req.lv_det_en  = pwr_one_q[stop_pkg::B_LV_DET];
    req.lv_stop_en = pwr_one_q[stop_pkg::B_LV_STOP];
    req.pd_sel     = pwr_two_q[stop_pkg::B_PD_SEL];
    req.ppd_sel    = pwr_two_q[stop_pkg::B_PPD_SEL];
    req.osc_keep   = clkstby_q[stop_pkg::B_OSC_KEEP];
    req.ref_keep   = clkstby_q[stop_pkg::B_REF_KEEP];
    req.timer_on   = clkstby_q[stop_pkg::B_TMR_ON];
    req.timer_ext  = clkstby_q[stop_pkg::B_TMR_EXT];
  end

  stop_level_resolver u_resolve (
    .req_in   (req),
    .plan_out (plan_now)
  );

  // ****************************************************************
  // Next-state logic.
  // ****************************************************************
  always_comb begin
    stop_go = (state_q == ST_RUN) && stop_exec_in && option_q[stop_pkg::B_PERMIT];
    lvd_active = (state_q == ST_RUN) ? pwr_one_q[stop_pkg::B_LV_DET] : plan_q.lvd_on;
    trip_evt  = lv_s && !lv_prev_q && lvd_active;
    rst_wake  = !rst_pin_n_s || (trip_evt && pwr_one_q[stop_pkg::B_LV_RST]);
    kbd_wake  = plan_q.kbd_wake && |(~kbd_s & kbd_en_q);
    tick_wake = plan_q.timer_wake && wake_tick_in;
    bg_wake   = plan_q.dbg_clk && dbg_cmd_in.valid && dbg_cmd_in.background;
    wake = (state_q == ST_STOP) && (rst_wake || !irq_n_s || kbd_wake || tick_wake || bg_wake);

    state_d     = state_q;
    plan_d      = plan_q;
    pwr_one_d   = pwr_one_q;
    pwr_two_d   = pwr_two_q;
    option_d    = option_q;
    debug_d     = debug_q;
    clkstby_d   = clkstby_q;
    kbd_en_d    = kbd_en_q;
    ppd_flag_d  = ppd_flag_q;
    lvd_flag_d  = lvd_flag_q;
    bg_active_d = bg_active_q;
    illegal_d   = (state_q == ST_RUN) && stop_exec_in && !option_q[stop_pkg::B_PERMIT];
    sys_reset_d = 1'b0;
    resume_d    = 1'b0;
    lvd_reset_d = trip_evt && pwr_one_q[stop_pkg::B_LV_RST];
    stat_d      = '0;
    rdata_d     = 8'h00;

    // Register writes.
    if (wr_in) begin
      case (addr_in)
        stop_pkg::OFS_PWR_ONE: begin
          pwr_one_d = {5'h00, wdata_in[2:0]};
          if (wdata_in[stop_pkg::B_LV_FLAG]) begin
            lvd_flag_d = 1'b0;
          end
        end
        stop_pkg::OFS_PWR_TWO: begin
          pwr_two_d = {6'h00, wdata_in[1:0]};
          if (wdata_in[stop_pkg::B_PPD_ACK]) begin
            ppd_flag_d = 1'b0;
          end
        end
        stop_pkg::OFS_OPTION:  option_d  = {7'h00, wdata_in[stop_pkg::B_PERMIT]};
        stop_pkg::OFS_DEBUG:   debug_d   = {7'h00, wdata_in[stop_pkg::B_DBG_EN]};
        stop_pkg::OFS_CLKSTBY: clkstby_d = {4'h0, wdata_in[3:0]};
        stop_pkg::OFS_KBD_EN:  kbd_en_d  = wdata_in[KBD_W-1:0];
        default: begin
        end
      endcase
    end

    // Register reads.
    if (rd_in) begin
      case (addr_in)
        stop_pkg::OFS_PWR_ONE: rdata_d = pwr_one_q | {4'h0, lvd_flag_q, 3'h0};
        stop_pkg::OFS_PWR_TWO: rdata_d = pwr_two_q | {5'h00, ppd_flag_q, 2'h0};
        stop_pkg::OFS_OPTION:  rdata_d = option_q;
        stop_pkg::OFS_DEBUG:   rdata_d = debug_q | {6'h00, bg_active_q, 1'b0};
        stop_pkg::OFS_CLKSTBY: rdata_d = clkstby_q;
        stop_pkg::OFS_KBD_EN:  rdata_d = 8'(kbd_en_q);
        stop_pkg::OFS_STATUS:  rdata_d = {4'h0, bg_active_q, state_q == ST_STOP, plan_q.level};
        default:               rdata_d = 8'h00;
      endcase
    end

    // Low-voltage flag: a trip wins over a clear in the same cycle.
    if (trip_evt) begin
      lvd_flag_d = 1'b1;
    end

    // Debug commands.
    if (dbg_cmd_in.valid) begin
      if (dbg_cmd_in.mem_status) begin
        stat_d.valid    = 1'b1;
        stat_d.stop_err = (state_q == ST_STOP);
      end
      if (state_q == ST_RUN && dbg_cmd_in.background && debug_q[stop_pkg::B_DBG_EN]) begin
        bg_active_d = 1'b1;
      end
      if (state_q == ST_RUN && dbg_cmd_in.go) begin
        bg_active_d = 1'b0;
      end
    end

    // Stop entry and wake-up.
    case (state_q)
      ST_RUN: begin
        if (stop_go) begin
          state_d = ST_STOP;
          plan_d  = plan_now;
        end
      end
      ST_STOP: begin
        if (wake) begin
          state_d = ST_RUN;
          if (plan_q.level != stop_pkg::LVL_LIGHT || rst_wake) begin
            sys_reset_d = 1'b1;
            pwr_one_d   = stop_pkg::PWR_ONE_RST;
            pwr_two_d   = stop_pkg::PWR_TWO_RST;
            option_d    = stop_pkg::OPTION_RST;
            debug_d     = stop_pkg::DEBUG_RST;
            clkstby_d   = stop_pkg::CLKSTBY_RST;
            kbd_en_d    = KBD_W'(stop_pkg::KBD_EN_RST);
            bg_active_d = 1'b0;
            if (plan_q.level == stop_pkg::LVL_MID) begin
              ppd_flag_d = 1'b1;
            end
          end else if (bg_wake) begin
            bg_active_d = 1'b1;
          end else begin
            resume_d = 1'b1;
          end
        end
      end
      default: state_d = ST_RUN;
    endcase

    stat_d.bg_active = bg_active_d;
    lvd_irq_d = lvd_flag_d && !pwr_one_d[stop_pkg::B_LV_RST];

    // Power domain controls follow the next state.
    pctl_d               = '0;
    pctl_d.periph_clk_en = 1'b1;
    pctl_d.dbg_clk_en    = 1'b1;
    pctl_d.reg_full      = 1'b1;
    pctl_d.ram_keep      = 1'b1;
    pctl_d.int1k_en      = clkstby_d[stop_pkg::B_TMR_ON];
    pctl_d.pin_hold      = ppd_flag_d;
    if (state_d == ST_STOP) begin
      pctl_d.periph_clk_en   = 1'b0;
      pctl_d.dbg_clk_en      = plan_d.dbg_clk;
      pctl_d.reg_full        = plan_d.reg_full;
      pctl_d.clkgen_standby  = plan_d.level == stop_pkg::LVL_LIGHT && !plan_d.dbg_clk;
      pctl_d.clkgen_off      = plan_d.level != stop_pkg::LVL_LIGHT;
      pctl_d.osc_keep        = plan_d.osc_keep;
      pctl_d.ref_keep        = plan_d.ref_keep;
      pctl_d.int1k_en        = plan_d.int1k_en;
      pctl_d.pin_hold        = plan_d.pin_hold || ppd_flag_d;
      pctl_d.pin_force_reset = plan_d.pin_force;
      pctl_d.ram_keep        = plan_d.ram_keep;
      pctl_d.conv_standby    = 1'b1;
      pctl_d.kbd_wake_en     = plan_d.kbd_wake;
      pctl_d.timer_wake_en   = plan_d.timer_wake;
    end
  end

  // ****************************************************************
  // Registers.
  // ****************************************************************
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q           <= ST_RUN;
      plan_q            <= '0;
      pwr_one_q         <= stop_pkg::PWR_ONE_RST;
      pwr_two_q         <= stop_pkg::PWR_TWO_RST;
      option_q          <= stop_pkg::OPTION_RST;
      debug_q           <= stop_pkg::DEBUG_RST;
      clkstby_q         <= stop_pkg::CLKSTBY_RST;
      kbd_en_q          <= KBD_W'(stop_pkg::KBD_EN_RST);
      ppd_flag_q        <= 1'b0;
      lvd_flag_q        <= 1'b0;
      bg_active_q       <= 1'b0;
      lv_prev_q         <= 1'b0;
      power_ctl_out     <= '0;
      dbg_stat_out      <= '0;
      rdata_out         <= 8'h00;
      illegal_reset_out <= 1'b0;
      sys_reset_out     <= 1'b0;
      resume_out        <= 1'b0;
      lvd_irq_out       <= 1'b0;
      lvd_reset_out     <= 1'b0;
    end else begin
      state_q           <= state_d;
      plan_q            <= plan_d;
      pwr_one_q         <= pwr_one_d;
      pwr_two_q         <= pwr_two_d;
      option_q          <= option_d;
      debug_q           <= debug_d;
      clkstby_q         <= clkstby_d;
      kbd_en_q          <= kbd_en_d;
      ppd_flag_q        <= ppd_flag_d;
      lvd_flag_q        <= lvd_flag_d;
      bg_active_q       <= bg_active_d;
      lv_prev_q         <= lv_s;
      power_ctl_out     <= pctl_d;
      dbg_stat_out      <= stat_d;
      rdata_out         <= rdata_d;
      illegal_reset_out <= illegal_d;
      sys_reset_out     <= sys_reset_d;
      resume_out        <= resume_d;
      lvd_irq_out       <= lvd_irq_d;
      lvd_reset_out     <= lvd_reset_d;
    end
  end

  assign stop_level_out = (state_q == ST_STOP) ? plan_q.level : stop_pkg::LVL_NONE;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_entry;
    (state_q == ST_RUN) && stop_exec_in && option_q[stop_pkg::B_PERMIT];
  endsequence

  sequence s_mid_wake;
    (state_q == ST_STOP) && (plan_q.level == stop_pkg::LVL_MID) && wake ##1 (state_q == ST_RUN);
  endsequence

  a_illegal_stop: assert property (
    (state_q == ST_RUN) && stop_exec_in && !option_q[stop_pkg::B_PERMIT]
    |=> illegal_reset_out && (state_q == ST_RUN))
    else $error("STOP without permit did not force an illegal opcode reset.");

  a_level_select: assert property (
    s_entry and (!req.dbg_en && !req.lv_stop_en && req.pd_sel && !req.ppd_sel)
    |=> stop_level_out == stop_pkg::LVL_DEEP)
    else $error("Deepest level was not entered when selected.");

  a_debug_force: assert property (
    s_entry and req.dbg_en |=> stop_level_out == stop_pkg::LVL_LIGHT)
    else $error("Debug entry did not force the lightest level.");

  a_lowvolt_force: assert property (
    s_entry and req.lv_stop_en |=> stop_level_out == stop_pkg::LVL_LIGHT)
    else $error("Low-voltage stop enable did not force the lightest level.");

  a_periph_gate: assert property (
    (state_q == ST_STOP) |-> !power_ctl_out.periph_clk_en && power_ctl_out.conv_standby)
    else $error("Peripheral clocks ran during stop.");

  a_debug_clock_reg: assert property (
    s_entry and req.dbg_en |=> power_ctl_out.dbg_clk_en && power_ctl_out.reg_full)
    else $error("Debug clock or regulator dropped with debug entry enabled.");

  a_reg_standby: assert property (
    s_entry and !req.dbg_en && !(req.lv_det_en && req.lv_stop_en) |=> !power_ctl_out.reg_full)
    else $error("Regulator stayed active without an override.");

  a_pin_force: assert property (
    (stop_level_out == stop_pkg::LVL_DEEP) |-> power_ctl_out.pin_force_reset
    && !power_ctl_out.ram_keep)
    else $error("Deepest level did not force pins to reset.");

  a_mem_status: assert property (
    (state_q == ST_STOP) && dbg_cmd_in.valid && dbg_cmd_in.mem_status
    |=> dbg_stat_out.valid && dbg_stat_out.stop_err)
    else $error("Memory status command in stop gave no stop error.");

  a_mid_hold: assert property (
    s_mid_wake |-> sys_reset_out && ppd_flag_q && power_ctl_out.pin_hold)
    else $error("Middle level wake did not reset and hold the pins.");

  a_no_1k_debug: assert property (
    (state_q == ST_STOP) && plan_q.dbg_clk |-> !power_ctl_out.int1k_en)
    else $error("The 1 kHz clock ran in stop with debug entry enabled.");

endmodule
`default_nettype wire

// ===== stop_wake_host.sv
// Background debug host and IRQ pin driver for the stop-mode controller.
// Assumes the controller samples both on rising edges of mclk_in.
`timescale 1ns/1ps
`default_nettype none
module stop_wake_host (
  input  wire logic               mclk_in,
  output var  logic               irq_pin_n_out,
  output var  stop_pkg::dbg_cmd_t dbg_cmd_out
);
  initial begin
    irq_pin_n_out = 1'b1;
    dbg_cmd_out   = '0;
  end
  // Holds the pin low for four cycles, long enough to pass the synchroniser, then drives it high again.
  task automatic pulse_irq();
    @(posedge mclk_in) irq_pin_n_out <= 1'b0;
    repeat (4) @(posedge mclk_in);
    irq_pin_n_out <= 1'b1;
  endtask
  // Sends one command for one cycle: bit 2 background, bit 1 status read, bit 0 go.
  task automatic send(input logic [2:0] c);
    @(posedge mclk_in) dbg_cmd_out <= {1'b1, c};
    @(posedge mclk_in) dbg_cmd_out <= '0;
  endtask
endmodule
`default_nettype wire

// ===== test_stop_mode_controller.sv
// Self-checking bench for the stop-mode controller.
// Assumes stop_pkg and stop_wake_host are compiled first.
`timescale 1ns/1ps
`default_nettype none
module test_stop_mode_controller;
  typedef struct packed {
    logic [7:0]       r1;
    logic [7:0]       r2;
    logic             dbg;
    stop_pkg::level_t lvl;
    logic             full;
  } row_t;
  logic mclk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, stop_exec_in = 0;
  logic [7:0] addr_in = 0, wdata_in = 0, rdata_out;
  logic ill, srst, res, lirq, lrst, irq_n;
  logic [7:0] kbd = 8'hFF;
  logic tick = 0, trip = 0;
  int n_srst = 0, n_res = 0, n_lrst = 0, srst0 = 0, res0 = 0;
  stop_pkg::dbg_cmd_t   cmd;
  stop_pkg::dbg_stat_t  stat;
  stop_pkg::power_ctl_t pc;
  stop_pkg::level_t     lvl;
  int n_errors = 0, checks_done = 0, cycles = 0;
  row_t rows [5] = '{
    '{8'h00, 8'h02, 1'b0, stop_pkg::LVL_DEEP, 1'b0},
    '{8'h00, 8'h03, 1'b0, stop_pkg::LVL_MID, 1'b0},
    '{8'h00, 8'h00, 1'b0, stop_pkg::LVL_LIGHT, 1'b0},
    '{8'h00, 8'h02, 1'b1, stop_pkg::LVL_LIGHT, 1'b1},
    '{8'h03, 8'h03, 1'b0, stop_pkg::LVL_LIGHT, 1'b1}};
  stop_wake_host u_host (.mclk_in(mclk_in), .irq_pin_n_out(irq_n), .dbg_cmd_out(cmd));
  stop_mode_controller u_dut (.mclk_in(mclk_in), .rst_in(rst_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .stop_exec_in(stop_exec_in), .rst_pin_n_in(1'b1), .irq_pin_n_in(irq_n),
    .kbd_pins_in(kbd), .wake_tick_in(tick), .lowvolt_trip_in(trip), .dbg_cmd_in(cmd),
    .dbg_stat_out(stat), .power_ctl_out(pc), .stop_level_out(lvl),
    .illegal_reset_out(ill), .sys_reset_out(srst), .resume_out(res),
    .lvd_irq_out(lirq), .lvd_reset_out(lrst));
  initial forever #4 mclk_in = ~mclk_in;
  task automatic give_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in) {addr_in, wdata_in, wr_in} <= {a, d, 1'b1};
    @(posedge mclk_in) wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk_in) {addr_in, rd_in} <= {a, 1'b1};
    @(posedge mclk_in) rd_in <= 1'b0;
    @(negedge mclk_in) chk("rdata", e, rdata_out);
  endtask
  task automatic stop();
    @(posedge mclk_in) stop_exec_in <= 1'b1;
    @(posedge mclk_in) stop_exec_in <= 1'b0;
    @(negedge mclk_in);
  endtask
  always @(posedge mclk_in) begin
    cycles <= cycles + 1;
    if (srst === 1'b1) n_srst <= n_srst + 1;
    if (res === 1'b1) n_res <= n_res + 1;
    if (lrst === 1'b1) n_lrst <= n_lrst + 1;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    @(negedge mclk_in) chk("periph_clk", 1'b1, pc.periph_clk_en);
    rd(8'h06, 8'h00);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(8'h02, 8'h01);
      wr(8'h00, rows[i].r1);
      wr(8'h01, rows[i].r2);
      wr(8'h03, {7'h00, rows[i].dbg});
      stop();
      chk("level", rows[i].lvl, lvl);
      chk("reg_full", rows[i].full, pc.reg_full);
      chk("periph_clk", 1'b0, pc.periph_clk_en);
      chk("pin_force", rows[i].lvl == stop_pkg::LVL_DEEP, pc.pin_force_reset);
      srst0 = n_srst;
      res0 = n_res;
      u_host.pulse_irq();
      @(negedge mclk_in) chk("wake", stop_pkg::LVL_NONE, lvl);
      chk("sys_reset", rows[i].lvl != stop_pkg::LVL_LIGHT, 8'(n_srst - srst0));
      chk("resume", rows[i].lvl == stop_pkg::LVL_LIGHT, 8'(n_res - res0));
      wr(8'h01, 8'h08);
    end
    $display("level table done");
    wr(8'h04, 8'h04);
    wr(8'h03, 8'h01);
    stop();
    chk("int1k", 1'b0, pc.int1k_en);
    chk("dbg_clk", 1'b1, pc.dbg_clk_en);
    u_host.send(3'b010);
    @(negedge mclk_in) chk("stop_err", 2'b11, {stat.valid, stat.stop_err});
    u_host.send(3'b100);
    @(negedge mclk_in) chk("bg_wake", stop_pkg::LVL_NONE, lvl);
    rd(8'h03, 8'h03);
    u_host.send(3'b001);
    rd(8'h03, 8'h01);
    $display("debug test done");
    wr(8'h00, 8'h00);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h03);
    stop();
    chk("mid_1k", 1'b1, pc.int1k_en);
    chk("mid_pins", 1'b1, pc.pin_hold);
    @(posedge mclk_in) tick <= 1'b1;
    @(posedge mclk_in) tick <= 1'b0;
    @(negedge mclk_in) chk("tick_wake", stop_pkg::LVL_NONE, lvl);
    chk("mid_reset", 1'b1, srst);
    chk("hold", 1'b1, pc.pin_hold);
    rd(8'h01, 8'h04);
    wr(8'h01, 8'h08);
    @(negedge mclk_in) chk("release", 1'b0, pc.pin_hold);
    wr(8'h02, 8'h01);
    wr(8'h05, 8'h01);
    stop();
    chk("kbd_en", 1'b1, pc.kbd_wake_en);
    res0 = n_res;
    @(posedge mclk_in) kbd <= 8'hFE;
    repeat (4) @(posedge mclk_in);
    kbd <= 8'hFF;
    @(negedge mclk_in) chk("kbd_wake", 8'h01, 8'(n_res - res0));
    wr(8'h00, 8'h07);
    stop();
    chk("lv_full", 1'b1, pc.reg_full);
    srst0 = n_srst;
    @(posedge mclk_in) trip <= 1'b1;
    repeat (4) @(posedge mclk_in);
    @(negedge mclk_in) chk("lv_reset", 8'h01, 8'(n_lrst));
    chk("lv_wake", 8'h01, 8'(n_srst - srst0));
    @(posedge mclk_in) trip <= 1'b0;
    wr(8'h00, 8'h08);
    @(negedge mclk_in) chk("lv_clear", 1'b0, lirq);
    wr(8'h00, 8'h01);
    @(posedge mclk_in) trip <= 1'b1;
    repeat (3) @(posedge mclk_in);
    @(negedge mclk_in) chk("lv_irq", 1'b1, lirq);
    $display("wake source test done");
    wr(8'h02, 8'h01);
    wr(8'h02, 8'h00);
    stop();
    chk("illegal", 1'b1, ill);
    chk("no_stop", stop_pkg::LVL_NONE, lvl);
    rd(8'h7F, 8'h00);
    $display("refusal test done");
    give_verdict();
  end
endmodule
`default_nettype wire
